// ==== src/cpfm_pin_mux.sv ====
// function select and gpio logic for the second multifunction pin and
// the two control-bus pins; registers reached over a simple control port
// assumes the control-port engine gives one-cycle read and write strobes,
// and that event sources and bus clock inputs run on core_clk
`timescale 1ns/1ns
`include "cpfm_regs.svh"

module cpfm_pin_mux
  import cpfm_pkg::*;
#(
  parameter int unsigned PULSE_CYC = `CPFM_PULSE_US * `CPFM_CLK_MHZ,
  parameter int unsigned JACK_CYC = `CPFM_JACK_US * `CPFM_CLK_MHZ
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rd_data,
  output logic reg_rd_valid,
  input wire logic flag_reg_read,
  input wire logic headset_evt,
  input wire logic button_evt,
  input wire logic short_evt,
  input wire logic agc_noise_evt,
  input wire logic second_multifunction_pin_in,
  output logic second_multifunction_pin_out,
  output logic second_multifunction_pin_oe,
  input wire logic dmic_clk_pin,
  output logic dmic_bit,
  output logic dmic_bit_valid,
  output logic dmic_bit_on_rise,
  input wire logic bclk_drive_out,
  input wire logic bclk_gen,
  output logic bclk_sensed,
  input wire logic select_pin,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic i2c_sda_pull_low,
  input wire logic i2c_scl_pull_low,
  output logic sda_sensed,
  output logic scl_sensed
);

  // control registers
  logic [3:0] func_ff;
  logic gpo_val_ff;
  logic dur_ff;
  logic [1:0] sda_use_ff;
  logic sda_val_ff;
  logic [1:0] scl_use_ff;
  logic scl_val_ff;

  // synchronised pins: mfp, mic clock, select, sda, scl
  logic [4:0] pins_raw;
  logic [4:0] pins_s;
  logic mfp_s;
  logic dclk_s;
  logic sel_s;
  logic sda_s;
  logic scl_s;

  assign pins_raw = {second_multifunction_pin_in, dmic_clk_pin, select_pin,
                     sda_in, scl_in};
  assign {mfp_s, dclk_s, sel_s, sda_s, scl_s} = pins_s;

  cpfm_sync #(
    .W(5)
  ) u_sync (
    .core_clk(core_clk),
    .rst(rst),
    .async_in(pins_raw),
    .sync_out(pins_s)
  );

  // register access decode
  logic hit_func;
  logic hit_twi;
  logic wr_func;
  logic wr_twi;

  assign hit_func = (reg_addr == `CPFM_ADDR_FUNC);
  assign hit_twi = (reg_addr == `CPFM_ADDR_TWI);
  assign wr_func = reg_wr_en && hit_func;
  assign wr_twi = reg_wr_en && hit_twi;

  // function decode of the second pin
  cpfm_role_t role;
  logic [3:0] src_mask;
  logic use_short;

  always_comb begin
    role = CPFM_ROLE_OFF;
    src_mask = `CPFM_SRC_NONE;
    use_short = 1'b0;
    unique case (func_ff)
      `CPFM_FN_OFF, `CPFM_FN_RSVD: role = CPFM_ROLE_OFF;
      `CPFM_FN_JACK: begin
        role = CPFM_ROLE_IRQ;
        src_mask = `CPFM_SRC_HS;
        use_short = 1'b1;
      end
      `CPFM_FN_GPI: role = CPFM_ROLE_GPI;
      `CPFM_FN_GPO: role = CPFM_ROLE_GPO;
      `CPFM_FN_DMIC_A, `CPFM_FN_DMIC_B, `CPFM_FN_DMIC_C: begin
        role = CPFM_ROLE_DMIC;
      end
      `CPFM_FN_BCLK: role = CPFM_ROLE_BCLK;
      `CPFM_FN_HS_BTN: begin
        role = CPFM_ROLE_IRQ;
        src_mask = `CPFM_SRC_HS_BTN;
      end
      `CPFM_FN_ALL: begin
        role = CPFM_ROLE_IRQ;
        src_mask = `CPFM_SRC_ALL;
      end
      `CPFM_FN_SC_BTN: begin
        role = CPFM_ROLE_IRQ;
        src_mask = `CPFM_SRC_SC_BTN;
      end
      `CPFM_FN_SC: begin
        role = CPFM_ROLE_IRQ;
        src_mask = `CPFM_SRC_SC;
      end
      // meaning of this code is unconfirmed, so the pin stays quiet
      `CPFM_FN_HOLD: role = CPFM_ROLE_OFF;
      `CPFM_FN_AGC: begin
        role = CPFM_ROLE_IRQ;
        src_mask = `CPFM_SRC_AGC;
      end
      `CPFM_FN_BTN: begin
        role = CPFM_ROLE_IRQ;
        src_mask = `CPFM_SRC_BTN;
      end
    endcase
  end

  // event selection and rising-edge trigger
  logic [3:0] evt_vec;
  logic evt_hit;
  logic evt_hit_d_ff;
  logic irq_trig;
  logic irq_enable;
  logic irq_level;

  assign evt_vec = {agc_noise_evt, short_evt, button_evt, headset_evt};
  assign evt_hit = |(evt_vec & src_mask);
  assign irq_trig = evt_hit && !evt_hit_d_ff;
  assign irq_enable = (role == CPFM_ROLE_IRQ);

  always_ff @(posedge core_clk) begin
    if (rst) begin
      evt_hit_d_ff <= 1'b0;
    end else begin
      evt_hit_d_ff <= evt_hit;
    end
  end

  cpfm_irq_pulse #(
    .LONG_CYC(PULSE_CYC),
    .SHORT_CYC(JACK_CYC)
  ) u_irq (
    .core_clk(core_clk),
    .rst(rst),
    .enable(irq_enable),
    .trig(irq_trig),
    .use_short(use_short),
    .repeat_mode(dur_ff),
    .stop(flag_reg_read),
    .irq_ff(irq_level)
  );

  // second pin drive
  logic nxt_mfp_out;
  logic nxt_mfp_oe;

  always_comb begin
    nxt_mfp_out = 1'b0;
    nxt_mfp_oe = 1'b0;
    unique case (role)
      CPFM_ROLE_IRQ: begin
        nxt_mfp_out = irq_level;
        nxt_mfp_oe = 1'b1;
      end
      CPFM_ROLE_GPO: begin
        nxt_mfp_out = gpo_val_ff;
        nxt_mfp_oe = 1'b1;
      end
      CPFM_ROLE_BCLK: begin
        nxt_mfp_out = bclk_gen;
        nxt_mfp_oe = bclk_drive_out;
      end
      CPFM_ROLE_OFF, CPFM_ROLE_GPI, CPFM_ROLE_DMIC: begin
        nxt_mfp_out = 1'b0;
        nxt_mfp_oe = 1'b0;
      end
    endcase
  end

  // mic data: one bit per mic clock edge, either direction
  logic dclk_d_ff;
  logic dclk_rise;
  logic dclk_fall;
  logic dmic_take;

  assign dclk_rise = dclk_s && !dclk_d_ff;
  assign dclk_fall = !dclk_s && dclk_d_ff;
  assign dmic_take = (role == CPFM_ROLE_DMIC) && (dclk_rise || dclk_fall);

  // two-wire pins: gpio only under spi select, else the i2c engine owns them
  logic sda_gpo;
  logic scl_gpo;
  logic nxt_sda_oe;
  logic nxt_scl_oe;
  logic sda_gpi_lvl;
  logic scl_gpi_lvl;
  logic mfp_gpi_lvl;

  assign sda_gpo = sel_s && (sda_use_ff == `CPFM_USE_OUT);
  assign scl_gpo = sel_s && (scl_use_ff == `CPFM_USE_OUT);
  // open drain: only a low is ever driven; reserved usage stays undriven
  assign nxt_sda_oe = sel_s ? (sda_gpo && !sda_val_ff)
                            : i2c_sda_pull_low;
  assign nxt_scl_oe = sel_s ? (scl_gpo && !scl_val_ff)
                            : i2c_scl_pull_low;
  assign sda_gpi_lvl = sel_s && (sda_use_ff == `CPFM_USE_IN) && sda_s;
  assign scl_gpi_lvl = sel_s && (scl_use_ff == `CPFM_USE_IN) && scl_s;
  assign mfp_gpi_lvl = (role == CPFM_ROLE_GPI) && mfp_s;

  // read data assembly; reserved bit 0 of the function register reads zero
  logic [7:0] func_rd;
  logic [7:0] twi_rd;
  logic [7:0] nxt_rd_data;

  assign func_rd = {func_ff, gpo_val_ff, mfp_gpi_lvl, dur_ff, 1'b0};
  assign twi_rd = {sda_use_ff, sda_val_ff, sda_gpi_lvl,
                   scl_use_ff, scl_val_ff, scl_gpi_lvl};
  assign nxt_rd_data = hit_func ? func_rd :
                       hit_twi ? twi_rd : `CPFM_REG_RESET;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      func_ff <= `CPFM_FN_OFF;
      gpo_val_ff <= 1'b0;
      dur_ff <= 1'b0;
    end else if (wr_func) begin
      // bit 0 is read-only and a write to it is dropped
      func_ff <= reg_wr_data[`CPFM_FUNC_MSB:`CPFM_FUNC_LSB];
      gpo_val_ff <= reg_wr_data[`CPFM_GPO_BIT];
      dur_ff <= reg_wr_data[`CPFM_DUR_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sda_use_ff <= `CPFM_USE_NONE;
      sda_val_ff <= 1'b0;
      scl_use_ff <= `CPFM_USE_NONE;
      scl_val_ff <= 1'b0;
    end else if (wr_twi) begin
      // stored as written even for reserved usage, so software sees it
      sda_use_ff <= reg_wr_data[`CPFM_SDA_MODE_MSB:`CPFM_SDA_MODE_LSB];
      sda_val_ff <= reg_wr_data[`CPFM_SDA_OUT_BIT];
      scl_use_ff <= reg_wr_data[`CPFM_SCL_MODE_MSB:`CPFM_SCL_MODE_LSB];
      scl_val_ff <= reg_wr_data[`CPFM_SCL_OUT_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      reg_rd_data <= `CPFM_REG_RESET;
      reg_rd_valid <= 1'b0;
    end else begin
      reg_rd_valid <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rd_data <= nxt_rd_data;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      second_multifunction_pin_out <= 1'b0;
      second_multifunction_pin_oe <= 1'b0;
      sda_out <= 1'b0;
      sda_oe <= 1'b0;
      scl_out <= 1'b0;
      scl_oe <= 1'b0;
    end else begin
      second_multifunction_pin_out <= nxt_mfp_out;
      second_multifunction_pin_oe <= nxt_mfp_oe;
      sda_out <= 1'b0;
      sda_oe <= nxt_sda_oe;
      scl_out <= 1'b0;
      scl_oe <= nxt_scl_oe;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      dclk_d_ff <= 1'b0;
      dmic_bit <= 1'b0;
      dmic_bit_valid <= 1'b0;
      dmic_bit_on_rise <= 1'b0;
    end else begin
      dclk_d_ff <= dclk_s;
      dmic_bit_valid <= dmic_take;
      if (dmic_take) begin
        dmic_bit <= mfp_s;
        dmic_bit_on_rise <= dclk_rise;
      end
    end
  end

  // sensed levels for the bus engines; bit clock only while selected
  always_ff @(posedge core_clk) begin
    if (rst) begin
      bclk_sensed <= 1'b0;
      sda_sensed <= 1'b0;
      scl_sensed <= 1'b0;
    end else begin
      bclk_sensed <= (role == CPFM_ROLE_BCLK) && !bclk_drive_out && mfp_s;
      sda_sensed <= sda_s;
      scl_sensed <= scl_s;
    end
  end

endmodule

// ==== include/cpfm_regs.svh ====
// register map, field positions, codes and timing figures of the pin mux
// assumes inclusion by bare name from design files of the pin mux block
`ifndef CPFM_REGS_SVH
`define CPFM_REGS_SVH

`define CPFM_ADDR_FUNC 8'h63
`define CPFM_ADDR_TWI 8'h64
`define CPFM_REG_RESET 8'h00

`define CPFM_FUNC_MSB 7
`define CPFM_FUNC_LSB 4
`define CPFM_GPO_BIT 3
`define CPFM_GPI_BIT 2
`define CPFM_DUR_BIT 1
`define CPFM_RSVD_BIT 0

`define CPFM_SDA_MODE_MSB 7
`define CPFM_SDA_MODE_LSB 6
`define CPFM_SDA_OUT_BIT 5
`define CPFM_SDA_IN_BIT 4
`define CPFM_SCL_MODE_MSB 3
`define CPFM_SCL_MODE_LSB 2
`define CPFM_SCL_OUT_BIT 1
`define CPFM_SCL_IN_BIT 0

`define CPFM_FN_OFF 4'h0
`define CPFM_FN_RSVD 4'h1
`define CPFM_FN_JACK 4'h2
`define CPFM_FN_GPI 4'h3
`define CPFM_FN_GPO 4'h4
`define CPFM_FN_DMIC_A 4'h5
`define CPFM_FN_DMIC_B 4'h6
`define CPFM_FN_DMIC_C 4'h7
`define CPFM_FN_BCLK 4'h8
`define CPFM_FN_HS_BTN 4'h9
`define CPFM_FN_ALL 4'hA
`define CPFM_FN_SC_BTN 4'hB
`define CPFM_FN_SC 4'hC
`define CPFM_FN_HOLD 4'hD
`define CPFM_FN_AGC 4'hE
`define CPFM_FN_BTN 4'hF

// event source mask bits: agc, short, button, headset
`define CPFM_SRC_NONE 4'h0
`define CPFM_SRC_HS 4'h1
`define CPFM_SRC_HS_BTN 4'h3
`define CPFM_SRC_ALL 4'hF
`define CPFM_SRC_SC_BTN 4'h6
`define CPFM_SRC_SC 4'h4
`define CPFM_SRC_AGC 4'h8
`define CPFM_SRC_BTN 4'h2

`define CPFM_USE_NONE 2'h0
`define CPFM_USE_IN 2'h1
`define CPFM_USE_OUT 2'h2

// times in microseconds, clock in MHz
`define CPFM_PULSE_US 2000
`define CPFM_JACK_US 1750
`define CPFM_CLK_MHZ 100

`endif

// ==== include/cpfm_pkg.sv ====
// types shared by the pin mux block
// assumes nothing beyond a SystemVerilog compiler
package cpfm_pkg;

  typedef enum logic [2:0] {
    CPFM_ROLE_OFF,
    CPFM_ROLE_IRQ,
    CPFM_ROLE_GPI,
    CPFM_ROLE_GPO,
    CPFM_ROLE_DMIC,
    CPFM_ROLE_BCLK
  } cpfm_role_t;

  typedef enum logic [1:0] {
    CPFM_IRQ_IDLE,
    CPFM_IRQ_HIGH,
    CPFM_IRQ_LOW
  } cpfm_irq_state_t;

endpackage

// ==== src/cpfm_sync.sv ====
// two-flop synchroniser for a group of pin inputs
// assumes each bit is an independent level from outside the clock domain
`timescale 1ns/1ns
module cpfm_sync #(
  parameter int W = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_ff;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      meta_ff <= '0;
      sync_out <= '0;
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end

endmodule

// ==== src/cpfm_irq_pulse.sv ====
// interrupt shaper: single timed pulse or repeating pulses until stopped
// assumes trig, stop and controls come from logic on core_clk
`timescale 1ns/1ns
module cpfm_irq_pulse
  import cpfm_pkg::*;
#(
  parameter int unsigned LONG_CYC = 200000,
  parameter int unsigned SHORT_CYC = 175000
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic enable,
  input wire logic trig,
  input wire logic use_short,
  input wire logic repeat_mode,
  input wire logic stop,
  output logic irq_ff
);

  localparam int CW = $clog2(LONG_CYC + 1);
  localparam logic [CW-1:0] LONG_LOAD = CW'(LONG_CYC - 1);
  localparam logic [CW-1:0] SHORT_LOAD = CW'(SHORT_CYC - 1);

  cpfm_irq_state_t state_ff, nxt_state;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic short_ff, nxt_short;
  logic [CW-1:0] load;

  assign load = short_ff ? SHORT_LOAD : LONG_LOAD;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_short = short_ff;
    if (!enable) begin
      nxt_state = CPFM_IRQ_IDLE;
      nxt_cnt = '0;
    end else if (trig) begin
      // a fresh event restarts the pulse, even over a pending stop
      nxt_state = CPFM_IRQ_HIGH;
      nxt_cnt = use_short ? SHORT_LOAD : LONG_LOAD;
      nxt_short = use_short;
    end else begin
      unique case (state_ff)
        CPFM_IRQ_IDLE: begin
          nxt_cnt = '0;
        end
        CPFM_IRQ_HIGH: begin
          if (repeat_mode && stop) begin
            nxt_state = CPFM_IRQ_IDLE;
          end else if (cnt_ff == '0) begin
            nxt_state = repeat_mode ? CPFM_IRQ_LOW : CPFM_IRQ_IDLE;
            nxt_cnt = load;
          end else begin
            nxt_cnt = cnt_ff - 1'b1;
          end
        end
        CPFM_IRQ_LOW: begin
          if (stop || !repeat_mode) begin
            nxt_state = CPFM_IRQ_IDLE;
          end else if (cnt_ff == '0) begin
            nxt_state = CPFM_IRQ_HIGH;
            nxt_cnt = load;
          end else begin
            nxt_cnt = cnt_ff - 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_ff <= CPFM_IRQ_IDLE;
      cnt_ff <= '0;
      short_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      short_ff <= nxt_short;
      irq_ff <= (nxt_state == CPFM_IRQ_HIGH);
    end
  end

endmodule

// ==== test/cpfm_pin_mux_chk.sv ====
// assertion checker for the pin mux, watching top-level ports only
// assumes a bind from the bench and short pulse lengths as parameters
`timescale 1ns/1ns
module cpfm_pin_mux_chk #(
  parameter int unsigned PULSE_CYC = 20,
  parameter int unsigned JACK_CYC = 15
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic flag_reg_read,
  input wire logic headset_evt,
  input wire logic button_evt,
  input wire logic short_evt,
  input wire logic agc_noise_evt,
  input wire logic second_multifunction_pin_out,
  input wire logic second_multifunction_pin_oe,
  input wire logic select_pin,
  input wire logic sda_oe,
  input wire logic scl_oe,
  input wire logic i2c_sda_pull_low
);
  logic [7:0] f_ff;
  logic [7:0] t_ff;
  logic [31:0] hi_ff;
  wire logic po = second_multifunction_pin_out;
  wire logic poe = second_multifunction_pin_oe;
  wire logic [3:0] fn = f_ff[7:4];
  wire logic [3:0] src = {agc_noise_evt, short_evt, button_evt, headset_evt};
  wire logic [3:0] msk = fn == 4'h2 ? 4'h1 : fn == 4'h9 ? 4'h3 :
    fn == 4'hA ? 4'hF : fn == 4'hB ? 4'h6 : fn == 4'hC ? 4'h4 :
    fn == 4'hE ? 4'h8 : fn == 4'hF ? 4'h2 : 4'h0;
  wire logic hit = |(msk & src);
  // shadow copies of the writable registers, updated on the write edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      f_ff <= 8'h00;
      t_ff <= 8'h00;
    end else if (reg_wr_en && reg_addr == 8'h63) begin
      f_ff <= reg_wr_data;
    end else if (reg_wr_en && reg_addr == 8'h64) begin
      t_ff <= reg_wr_data;
    end
  end
  // length of the current high run on the pin
  always_ff @(posedge core_clk) begin
    if (rst || !po) begin
      hi_ff <= 32'h0000_0000;
    end else begin
      hi_ff <= hi_ff + 32'h0000_0001;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // select must have settled through the synchroniser
  sequence sel_hi;
    select_pin [*4];
  endsequence
  sequence sel_lo;
    !select_pin [*4];
  endsequence
  AST_RST: assert property ($fell(rst) |-> !poe && !sda_oe && !scl_oe)
    else $error("outputs driven after reset");
  AST_OFF: assert property (fn inside {4'h0, 4'h1, 4'h3, 4'h5, 4'h6, 4'h7,
    4'hD} |=> !poe)
    else $error("pin driven in an input or off function");
  AST_GPO: assert property (fn == 4'h4 |=> poe && po == $past(f_ff[3]))
    else $error("output level differs from value bit");
  // shaper output register plus pin register: pin rises two cycles on
  AST_TRIG: assert property ($stable(fn) &&
    $rose(hit) |-> ##2 po)
    else $error("selected event did not raise the pin");
  AST_ONE: assert property ($fell(po) && $stable(fn) && !f_ff[1] &&
    $past(fn, 2) == fn && msk != 4'h0 |->
    hi_ff == (fn == 4'h2 ? JACK_CYC : PULSE_CYC))
    else $error("single pulse length wrong");
  AST_STOP: assert property (f_ff[1] && msk != 4'h0 && flag_reg_read
    && !$rose(hit) |-> ##2 !po [*3])
    else $error("repeat pulses not stopped by flag read");
  AST_SDA: assert property (sel_hi ##0 t_ff[7:6] == 2'h2
    |=> sda_oe == !$past(t_ff[5]))
    else $error("sda output level wrong");
  AST_SCL: assert property (sel_hi ##0 t_ff[3:2] == 2'h2
    |=> scl_oe == !$past(t_ff[1]))
    else $error("scl output level wrong");
  AST_RSV: assert property (sel_hi ##0 t_ff[7:6] != 2'h2 |=> !sda_oe)
    else $error("sda pulled while not an output");
  AST_I2C: assert property (sel_lo |=> sda_oe == $past(i2c_sda_pull_low))
    else $error("sda not left to the bus engine");
endmodule

// ==== test/cpfm_pin_ext.sv ====
// far-side pin circuitry: pull-ups on both two-wire pins, a driver on
// the second pin; assumes the bench steers the ext inputs off the edge
`timescale 1ns/1ns
module cpfm_pin_ext (
  input wire logic pin_oe,
  input wire logic pin_out,
  input wire logic pin_ext,
  output logic pin_lvl,
  input wire logic sda_oe,
  input wire logic sda_out,
  input wire logic sda_ext_low,
  output logic sda_lvl,
  input wire logic scl_oe,
  input wire logic scl_out,
  input wire logic scl_ext_low,
  output logic scl_lvl
);
  // released pin shows the outside driver, never a held last value
  assign pin_lvl = pin_oe ? pin_out : pin_ext;
  // open drain: pull-up wins unless some party pulls low
  assign sda_lvl = (sda_oe ? sda_out : 1'b1) && !sda_ext_low;
  assign scl_lvl = (scl_oe ? scl_out : 1'b1) && !scl_ext_low;
endmodule

// ==== test/codec_pin_function_mux_gpio_tb.sv ====
// bench for the pin mux: registers, events and pins driven at the falling
// edge against its own model; assumes the checker is bound from here
`timescale 1ns/1ns
module codec_pin_function_mux_gpio_tb;
  // short pulses keep the run small
  localparam int unsigned PC = 20;
  localparam int unsigned JC = 15;
  logic core_clk, rst, reg_wr_en, reg_rd_en, reg_rd_valid, flag_rd;
  logic [7:0] reg_addr, reg_wr_data, reg_rd_data;
  logic [3:0] evt;
  logic pin_ext, pin_lvl, pin_out, pin_oe, dmic_clk, dmic_bit, dmic_ok;
  logic dmic_rise, bclk_drv, bclk_gen, bclk_sensed, select_pin, c;
  logic sda_out, sda_oe, scl_out, scl_oe, sda_low, scl_low, sda_lvl, scl_lvl;
  logic i2c_sda, i2c_scl, sda_sensed, scl_sensed;
  int err_count, n_checks, seed, m63, m64, f, s, u, w, b;

  cpfm_pin_mux #(.PULSE_CYC(PC), .JACK_CYC(JC)) DUT (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
    .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
    .reg_rd_valid(reg_rd_valid), .flag_reg_read(flag_rd),
    .headset_evt(evt[0]), .button_evt(evt[1]), .short_evt(evt[2]),
    .agc_noise_evt(evt[3]), .second_multifunction_pin_in(pin_lvl),
    .second_multifunction_pin_out(pin_out),
    .second_multifunction_pin_oe(pin_oe), .dmic_clk_pin(dmic_clk),
    .dmic_bit(dmic_bit), .dmic_bit_valid(dmic_ok),
    .dmic_bit_on_rise(dmic_rise), .bclk_drive_out(bclk_drv),
    .bclk_gen(bclk_gen), .bclk_sensed(bclk_sensed),
    .select_pin(select_pin), .sda_in(sda_lvl), .sda_out(sda_out),
    .sda_oe(sda_oe), .scl_in(scl_lvl), .scl_out(scl_out), .scl_oe(scl_oe),
    .i2c_sda_pull_low(i2c_sda), .i2c_scl_pull_low(i2c_scl),
    .sda_sensed(sda_sensed), .scl_sensed(scl_sensed));

  cpfm_pin_ext ext (.pin_oe(pin_oe), .pin_out(pin_out), .pin_ext(pin_ext),
    .pin_lvl(pin_lvl), .sda_oe(sda_oe), .sda_out(sda_out),
    .sda_ext_low(sda_low), .sda_lvl(sda_lvl), .scl_oe(scl_oe),
    .scl_out(scl_out), .scl_ext_low(scl_low), .scl_lvl(scl_lvl));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic final_report;
    if (err_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic cyc(int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    cyc(1);
    reg_wr_en = 1'b0;
    if (a == 8'h63) m63 = d & 8'hFA;
    if (a == 8'h64) m64 = d & 8'hEE;
    // let an edge pass so a following call never re-raises the strobe
    cyc(1);
  endtask

  task automatic rd(logic [7:0] a, logic [7:0] e);
    reg_addr = a;
    reg_rd_en = 1'b1;
    cyc(1);
    reg_rd_en = 1'b0;
    chk("rd_valid", 8'h01, 8'(reg_rd_valid));
    chk("rd_data", e, reg_rd_data);
    cyc(1);
  endtask

  // sources per code, bits agc, short, button, headset
  function automatic logic [3:0] msk(int fc);
    case (fc)
      2: return 4'h1;
      9: return 4'h3;
      10: return 4'hF;
      11: return 4'h6;
      12: return 4'h4;
      14: return 4'h8;
      15: return 4'h2;
      default: return 4'h0;
    endcase
  endfunction

  function automatic logic [7:0] e63();
    return {m63[7:3], m63[7:4] == 3 ? pin_lvl : 1'b0, m63[1], 1'b0};
  endfunction

  function automatic logic [7:0] e64();
    return {m64[7:5], select_pin && m64[7:6] == 1 ? sda_lvl : 1'b0,
      m64[3:1], select_pin && m64[3:2] == 1 ? scl_lvl : 1'b0};
  endfunction

  initial begin
    seed = 87087;
    {reg_wr_en, reg_rd_en, flag_rd, reg_addr, reg_wr_data, evt} = '0;
    {pin_ext, dmic_clk, bclk_gen, select_pin, sda_low, scl_low} = '0;
    {i2c_sda, i2c_scl, err_count, n_checks, m63, m64} = '0;
    bclk_drv = 1'b1;
    rst = 1'b1;
    cyc(2);
    rst = 1'b0;
    rd(8'h63, 8'h00);
    rd(8'h64, 8'h00);
    rd(8'h20, 8'h00);
    for (f = 0; f < 16; f++) begin
      pin_ext = 1'($random(seed));
      bclk_gen = 1'($random(seed));
      wr(8'h63, 8'(f << 4));
      cyc(2);
      chk("pin_oe", 8'(msk(f) != 0 || f == 4 || f == 8), 8'(pin_oe));
      if (f == 8) chk("bclk_out", 8'(bclk_gen), 8'(pin_out));
      rd(8'h63, e63());
    end
    wr(8'h48, 8'h00);
    for (w = 0; w < 2; w++) begin
      wr(8'h63, 8'(w == 0 ? 8'h48 : 8'h40));
      cyc(2);
      chk("gpo", 8'(w == 0), 8'(pin_out));
    end
    // every source against every interrupt code, single pulse form
    for (f = 2; f < 16; f++) begin
      for (s = 0; s < 4 && msk(f) != 0; s++) begin
        wr(8'h63, 8'(f << 4));
        cyc(2);
        evt = 4'h1 << s;
        cyc(2);
        b = msk(f) >> s & 1;
        chk("irq_hit", 8'(b), 8'(pin_out));
        evt = 4'h0;
        cyc((f == 2 ? JC : PC) + 3);
        chk("irq_end", 8'h00, 8'(pin_out));
      end
    end
    wr(8'h63, 8'h92);
    evt = 4'h1;
    cyc(1);
    evt = 4'h0;
    cyc(PC + 5);
    chk("rep_low", 8'h00, 8'(pin_out));
    cyc(PC);
    chk("rep_high", 8'h01, 8'(pin_out));
    flag_rd = 1'b1;
    cyc(1);
    flag_rd = 1'b0;
    cyc(2 * PC + 4);
    chk("rep_stop", 8'h00, 8'(pin_out));
    select_pin = 1'b1;
    for (u = 0; u < 3; u++) begin
      for (w = 0; w < 2; w++) begin
        c = 1'($random(seed));
        sda_low = 1'($random(seed));
        scl_low = 1'($random(seed));
        wr(8'h64, {u[1:0], w[0], 1'b0, u[1:0], c, 1'b0});
        cyc(4);
        chk("sda_oe", 8'(u == 2 && w == 0), 8'(sda_oe));
        chk("scl_oe", 8'(u == 2 && !c), 8'(scl_oe));
        rd(8'h64, e64());
      end
    end
    select_pin = 1'b0;
    for (w = 0; w < 4; w++) begin
      i2c_sda = 1'($random(seed));
      i2c_scl = 1'($random(seed));
      cyc(4);
      chk("i2c_sda", 8'(i2c_sda), 8'(sda_oe));
      chk("i2c_scl", 8'(i2c_scl), 8'(scl_oe));
      chk("sda_sense", 8'(sda_lvl), 8'(sda_sensed));
      chk("scl_sense", 8'(scl_lvl), 8'(scl_sensed));
      chk("od_out", 8'h00, 8'({sda_out, scl_out}));
    end
    wr(8'h63, 8'h50);
    for (w = 0; w < 4; w++) begin
      pin_ext = 1'($random(seed));
      cyc(3);
      dmic_clk = ~dmic_clk;
      for (s = 0; s < 8 && dmic_ok !== 1'b1; s++) begin
        cyc(1);
      end
      chk("mic_wait", 8'h00, 8'(s == 8));
      if (s == 8) final_report();
      chk("mic_edge", 8'(dmic_clk), 8'(dmic_rise));
      chk("mic_bit", 8'(pin_ext), 8'(dmic_bit));
    end
    bclk_drv = 1'b0;
    wr(8'h63, 8'h80);
    cyc(4);
    chk("bclk_in", 8'(pin_ext), 8'(bclk_sensed));
    final_report();
  end
endmodule

bind cpfm_pin_mux cpfm_pin_mux_chk #(.PULSE_CYC(PULSE_CYC),
  .JACK_CYC(JACK_CYC)) chk_i (.core_clk, .rst, .reg_addr, .reg_wr_en,
  .reg_wr_data, .flag_reg_read, .headset_evt, .button_evt, .short_evt,
  .agc_noise_evt, .second_multifunction_pin_out,
  .second_multifunction_pin_oe, .select_pin, .sda_oe, .scl_oe,
  .i2c_sda_pull_low);
